/* rtl/irq_pkg.sv */
// Constants and carrier types for the vectored interrupt arbiter
package irq_pkg;
    localparam int          NUM_SRC        = 8;
    // Source ranks, also their bit positions in the pending register
    localparam int          RANK_RESET     = 0;
    localparam int          RANK_NMI       = 1;
    localparam int          RANK_LINE_TWO  = 2;
    localparam int          RANK_LINE_THR  = 3;
    localparam int          RANK_LINE_FOUR = 4;
    localparam int          RANK_TIMERS    = 5;
    localparam int          RANK_UART      = 6;
    localparam int          RANK_END_MSG   = 7;
    // Vector word of rank r sits at RESET_VECTOR - 2*r
    localparam logic [15:0] RESET_VECTOR   = 16'hfffe;
    localparam logic [15:0] LOWEST_VECTOR  = 16'hfff0;
    localparam logic [15:0] SP_STEP        = 16'h0002;
    // Enable register: bit 0 global enable, bits 2..7 individual enables
    localparam int          GLOBAL_EN_BIT  = 0;
    localparam logic [7:0]  ENABLE_MASK    = 8'hfd;
    // NMI and external lines clear their pending bit on entry; timer, UART and end-of-message do not
    localparam logic [7:0]  AUTO_CLR_MASK  = 8'h1e;
    // Condition register: bit 0 line two, bit 1 line three, bit 2 line four
    localparam int          COND_WIDTH     = 3;
    localparam logic [7:0]  ENABLE_RESET   = 8'h00;
    localparam logic [7:0]  PENDING_RESET  = 8'h01;
    localparam logic [2:0]  COND_RESET     = 3'h0;
    localparam logic [15:0] SP_RESET       = 16'h0000;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic        load;
        logic [15:0] value;
    } pc_load_t;
endpackage

/* rtl/irq_edge_detect.sv */
// Edge detector with selectable polarity for one interrupt input
`timescale 1ns/1ns
module irq_edge_detect (
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Input line and polarity, 1 selects falling edge
    input  wire logic sig,
    input  wire logic fall_sel,
    // One-cycle pulse on the selected edge
    output logic      hit
);
    logic prev_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= sig;
        end
    end

    assign hit = fall_sel ? (prev_q & ~sig) : (~prev_q & sig);
endmodule // irq_edge_detect

/* rtl/vectored_interrupt_arbiter.sv */
// Vectored interrupt arbiter with pending, enable, polarity and entry/return sequencing
`timescale 1ns/1ns
module vectored_interrupt_arbiter (
    // Clock and active-low chip reset
    input  wire logic                clk,
    input  wire logic                arst_n,
    // Interrupt sources
    input  wire logic                nmi_in,
    input  wire logic                external_line_two,
    input  wire logic                external_line_three,
    input  wire logic                external_line_four,
    input  wire logic                hdlc_dma_error,
    input  wire logic                timer_irq,
    input  wire logic                uart_irq,
    input  wire logic                end_of_message_source,
    // Software access to control registers
    input  wire logic                enable_wr,
    input  wire logic [7:0]          enable_wdata,
    input  wire logic                pending_wr,
    input  wire logic [7:0]          pending_wdata,
    input  wire logic                cond_wr,
    input  wire logic [2:0]          cond_wdata,
    input  wire logic                sp_wr,
    input  wire logic [15:0]         sp_wdata,
    output logic [7:0]               interrupt_enable_reg,
    output logic [7:0]               interrupt_pending_reg,
    output logic [2:0]               interrupt_condition_reg,
    output logic [15:0]              stack_pointer,
    // Core sequencer
    input  wire logic                instr_boundary,
    input  wire logic                return_from_service_instr,
    input  wire logic [15:0]         pc_in,
    output irq_pkg::pc_load_t        pc_load,
    output logic                     entry_busy,
    output logic [2:0]               grant_rank,
    // Memory port for stack and vector access
    output irq_pkg::mem_req_t        mem,
    input  wire logic                mem_ack,
    input  wire logic [15:0]         mem_rdata,
    // DMA and port control
    input  wire logic                dma_byte_busy,
    output logic                     dma_halt,
    output logic [15:0]              port_b_float,
    output logic                     port_a_float,
    output logic                     port_d_float,
    output logic                     port_r_float
);
    typedef enum logic [2:0] {S_IDLE, S_DMA_WAIT, S_PUSH, S_FETCH, S_POP} state_t;

    state_t      state_q;
    logic [7:0]  enable_q;
    logic [7:0]  pending_q;
    logic [2:0]  cond_q;
    logic [15:0] sp_q;
    logic [2:0]  rank_q;
    logic        nmi_active_q;
    logic        reset_float_q;
    logic [15:0] saved_pc_q;
    logic [7:1]  trig;
    logic [7:1]  edge_in;
    logic [7:1]  fall_sel;
    logic [7:0]  qualify;
    logic        any_req;
    logic [2:0]  win_rank;
    logic        take;
    logic        take_nmi;
    logic [7:0]  entry_clr;
    logic [15:0] vector_addr;

    // Edge-triggered sources; line four slot shares the HDLC/DMA error
    assign edge_in  = {end_of_message_source, uart_irq, timer_irq, external_line_four,
                       external_line_three, external_line_two, nmi_in};
    assign fall_sel = {3'h0, cond_q, 1'b0};

    for (genvar i = 1; i < irq_pkg::NUM_SRC; i++) begin : g_edge
        irq_edge_detect u_edge (
            .clk     (clk),
            .arst_n  (arst_n),
            .sig     (edge_in[i]),
            .fall_sel(fall_sel[i]),
            .hit     (trig[i])
        );
    end

    logic err_prev_q;
    logic err_hit;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            err_prev_q <= 1'b0;
        end else begin
            err_prev_q <= hdlc_dma_error;
        end
    end
    assign err_hit = ~err_prev_q & hdlc_dma_error;

    // Qualification: NMI always, maskable need own and global enable
    always_comb begin
        qualify = pending_q & {enable_q[7:2] & {6{enable_q[irq_pkg::GLOBAL_EN_BIT]}}, 2'b10};
        any_req = |qualify;
        win_rank = 3'h0;
        for (int r = irq_pkg::NUM_SRC - 1; r >= 0; r--) begin
            if (qualify[r]) begin
                win_rank = r[2:0];
            end
        end
    end

    // Maskable entries wait for an instruction boundary; reset is handled separately
    assign take     = (state_q == S_IDLE) && !pending_q[irq_pkg::RANK_RESET]
                      && instr_boundary && any_req;
    assign take_nmi = take && (win_rank == 3'(irq_pkg::RANK_NMI));
    assign vector_addr = irq_pkg::RESET_VECTOR - {12'h000, rank_q, 1'b0};

    always_comb begin
        entry_clr = 8'h00;
        if (take) begin
            entry_clr[win_rank] = irq_pkg::AUTO_CLR_MASK[win_rank];
        end
        if (state_q == S_FETCH && rank_q == 3'(irq_pkg::RANK_RESET) && mem_ack) begin
            entry_clr[irq_pkg::RANK_RESET] = 1'b1;
        end
    end

    // Pending register: hardware set wins over software write and entry clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pending_q <= irq_pkg::PENDING_RESET;
        end else begin
            pending_q <= ((pending_wr ? pending_wdata : pending_q) & ~entry_clr)
                         | {trig[7:5], trig[4] | err_hit, trig[3:1], 1'b0};
        end
    end

    // Enable register: entry clears global enable, return sets it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            enable_q <= irq_pkg::ENABLE_RESET;
        end else if (take) begin
            enable_q[irq_pkg::GLOBAL_EN_BIT] <= 1'b0;
        end else if (state_q == S_POP && mem_ack) begin
            enable_q[irq_pkg::GLOBAL_EN_BIT] <= 1'b1;
        end else if (enable_wr) begin
            enable_q <= enable_wdata & irq_pkg::ENABLE_MASK;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cond_q <= irq_pkg::COND_RESET;
        end else if (cond_wr) begin
            cond_q <= cond_wdata;
        end
    end

    // Stack pointer: +2 on push, -2 on pop
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sp_q <= irq_pkg::SP_RESET;
        end else if (state_q == S_PUSH && mem_ack) begin
            sp_q <= sp_q + irq_pkg::SP_STEP;
        end else if (state_q == S_POP && mem_ack) begin
            sp_q <= sp_q - irq_pkg::SP_STEP;
        end else if (sp_wr && state_q == S_IDLE) begin
            sp_q <= sp_wdata;
        end
    end

    // Entry and return sequencer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q    <= S_IDLE;
            rank_q     <= 3'(irq_pkg::RANK_RESET);
            saved_pc_q <= 16'h0000;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    if (pending_q[irq_pkg::RANK_RESET]) begin
                        rank_q  <= 3'(irq_pkg::RANK_RESET);
                        state_q <= S_FETCH;
                    end else if (take) begin
                        rank_q     <= win_rank;
                        saved_pc_q <= pc_in;
                        state_q    <= take_nmi ? S_DMA_WAIT : S_PUSH;
                    end else if (return_from_service_instr) begin
                        state_q <= S_POP;
                    end
                end
                S_DMA_WAIT: begin
                    if (!dma_byte_busy) begin
                        state_q <= S_PUSH;
                    end
                end
                S_PUSH: begin
                    if (mem_ack) begin
                        state_q <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    if (mem_ack) begin
                        state_q <= S_IDLE;
                    end
                end
                S_POP: begin
                    if (mem_ack) begin
                        state_q <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // DMA halt held from NMI entry until the next return; HDLC is never stopped here
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            nmi_active_q <= 1'b0;
        end else if (take_nmi) begin
            nmi_active_q <= 1'b1;
        end else if (state_q == S_POP && mem_ack) begin
            nmi_active_q <= 1'b0;
        end
    end

    // Ports A, D, R and all of port B but bit 12 float from reset until the reset vector has been fetched
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reset_float_q <= 1'b1;
        end else if (entry_clr[irq_pkg::RANK_RESET]) begin
            reset_float_q <= 1'b0;
        end
    end

    // Memory request, PC load and status outputs
    always_comb begin
        mem = '0;
        unique case (state_q)
            S_PUSH: begin
                mem.req   = 1'b1;
                mem.we    = 1'b1;
                mem.addr  = sp_q;
                mem.wdata = saved_pc_q;
            end
            S_FETCH: begin
                mem.req  = 1'b1;
                mem.addr = vector_addr;
            end
            S_POP: begin
                mem.req  = 1'b1;
                mem.addr = sp_q - irq_pkg::SP_STEP;
            end
            default: begin
                mem = '0;
            end
        endcase
    end

    assign pc_load.load  = (state_q == S_FETCH || state_q == S_POP) && mem_ack;
    assign pc_load.value = mem_rdata;
    assign entry_busy    = (state_q != S_IDLE);
    assign grant_rank    = rank_q;
    assign dma_halt      = nmi_active_q || take_nmi;
    assign port_a_float  = reset_float_q;
    assign port_d_float  = reset_float_q;
    assign port_r_float  = reset_float_q;
    assign port_b_float  = {3'h7, 1'b0, {12{reset_float_q}}} & {16{reset_float_q}};

    assign interrupt_enable_reg    = enable_q;
    assign interrupt_pending_reg   = pending_q;
    assign interrupt_condition_reg = cond_q;
    assign stack_pointer           = sp_q;
endmodule // vectored_interrupt_arbiter

/* test/mem_model.sv */
// Memory partner that answers stack pushes, pops and vector fetches
`timescale 1ns/1ns
module mem_model (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // Request side and wait states
    input  wire irq_pkg::mem_req_t mem,
    input  wire logic [1:0]        ack_dly,
    // Answer
    output logic                   mem_ack,
    output logic [15:0]            mem_rdata
);
    logic [1:0]  cnt_q;
    logic [15:0] last_q;
    logic [15:0] ram [0:31];

    assign mem_ack = mem.req && (cnt_q == ack_dly);

    // Vector words read back as the inverted address; idle data is never stale
    always_comb begin
        if (!mem_ack) mem_rdata = ~last_q;
        else if (mem.addr[15:8] == 8'hff) mem_rdata = ~mem.addr;
        else mem_rdata = ram[mem.addr[5:1]];
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q  <= 2'h0;
            last_q <= 16'h0000;
        end else begin
            cnt_q <= (mem.req && !mem_ack) ? cnt_q + 2'h1 : 2'h0;
            if (mem_ack) last_q <= mem_rdata;
            if (mem_ack && mem.we) ram[mem.addr[5:1]] <= mem.wdata;
        end
    end
endmodule // mem_model

/* test/vectored_interrupt_arbiter_sva.sv */
// Port-level assertions for the vectored interrupt arbiter
`timescale 1ns/1ns
module irq_checker (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // Observed ports
    input  wire logic              timer_irq,
    input  wire logic              instr_boundary,
    input  wire logic              return_from_service_instr,
    input  wire logic [7:0]        interrupt_enable_reg,
    input  wire logic [7:0]        interrupt_pending_reg,
    input  wire logic [15:0]       stack_pointer,
    input  wire irq_pkg::pc_load_t pc_load,
    input  wire logic              entry_busy,
    input  wire logic [2:0]        grant_rank,
    input  wire irq_pkg::mem_req_t mem,
    input  wire logic              mem_ack,
    input  wire logic [15:0]       mem_rdata,
    input  wire logic              dma_halt,
    input  wire logic [15:0]       port_b_float,
    input  wire logic              port_a_float,
    input  wire logic              port_d_float,
    input  wire logic              port_r_float
);
    logic [7:0] qual;
    logic       take;

    function automatic logic [2:0] low_rank(input logic [7:0] v);
        low_rank = 3'h0;
        for (int i = 7; i >= 0; i--) if (v[i]) low_rank = 3'(i);
    endfunction

    assign qual = {interrupt_pending_reg[7:2] & interrupt_enable_reg[7:2]
                   & {6{interrupt_enable_reg[0]}}, interrupt_pending_reg[1], 1'b0};
    assign take = !entry_busy && instr_boundary && !interrupt_pending_reg[0] && (qual != 8'h00);

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    AST_TAKE_AT_BOUNDARY: assert property (take |=> entry_busy)
        else $error("no entry after qualified boundary");
    AST_NO_QUALIFIER: assert property (
        !entry_busy && instr_boundary && !return_from_service_instr
        && !interrupt_pending_reg[0] && qual == 8'h00 |=> !entry_busy)
        else $error("entry without qualifying source");
    AST_LOWEST_RANK: assert property (take |=> grant_rank == low_rank($past(qual)))
        else $error("wrong rank granted");
    AST_GLB_CLEARED: assert property (take |=> !interrupt_enable_reg[0])
        else $error("global enable kept on entry");
    AST_EXT_AUTOCLR: assert property (
        take && low_rank(qual) == 3'h2 |=> !interrupt_pending_reg[2])
        else $error("line two pending not cleared");
    AST_NMI_HALTS_DMA: assert property (take && low_rank(qual) == 3'h1 |=> dma_halt)
        else $error("dma not halted on nmi entry");
    AST_PUSH_SP: assert property (
        mem.req && mem.we && mem_ack |=> stack_pointer == $past(stack_pointer) + 16'h0002)
        else $error("stack pointer not advanced by two");
    AST_PC_FROM_READ: assert property (
        mem.req && !mem.we && mem_ack |-> pc_load.load && pc_load.value == mem_rdata)
        else $error("pc not loaded from read word");
    AST_POP_RESTORE: assert property (
        mem.req && !mem.we && mem_ack && mem.addr[15:8] != 8'hff
        |=> interrupt_enable_reg[0] && stack_pointer == $past(stack_pointer) - 16'h0002)
        else $error("return did not restore enable and stack");
    AST_FLOAT_IN_RESET: assert property (
        interrupt_pending_reg[0] |-> port_a_float && port_d_float && port_r_float
        && port_b_float == 16'hefff)
        else $error("ports not floated before reset fetch");
    AST_EDGE_PENDS: assert property (
        $rose(timer_irq) |-> ##[1:2] interrupt_pending_reg[5])
        else $error("timer edge not pending");
endmodule // irq_checker

bind vectored_interrupt_arbiter irq_checker i_chk (.*);

/* test/vectored_interrupt_arbiter_tb.sv */
// Self-checking bench for the vectored interrupt arbiter
`timescale 1ns/1ns
module vectored_interrupt_arbiter_tb;
    typedef struct packed {
        logic [7:0] src;
        logic [7:0] en;
        logic [7:0] pend;
        logic [2:0] rank;
    } row_t;
    logic              clk = 0, arst_n, nmi_in, external_line_two, external_line_three;
    logic              external_line_four, hdlc_dma_error, timer_irq, uart_irq;
    logic              end_of_message_source, enable_wr, pending_wr, cond_wr, sp_wr;
    logic              instr_boundary, return_from_service_instr, mem_ack, dma_byte_busy;
    logic              entry_busy, dma_halt, port_a_float, port_d_float, port_r_float;
    logic [7:0]        enable_wdata, pending_wdata, interrupt_enable_reg, interrupt_pending_reg;
    logic [2:0]        cond_wdata, interrupt_condition_reg, grant_rank;
    logic [15:0]       sp_wdata, stack_pointer, pc_in, mem_rdata, port_b_float, last_pc;
    logic [1:0]        ack_dly;
    irq_pkg::pc_load_t pc_load;
    irq_pkg::mem_req_t mem;
    int                num_errors = 0, cmp_count = 0;
    row_t              rows [6] = '{'{8'h04, 8'h05, 8'h00, 3'h2}, '{8'h0c, 8'h0d, 8'h08, 3'h2},
        '{8'h18, 8'h11, 8'h08, 3'h4}, '{8'he0, 8'hc1, 8'he0, 3'h6},
        '{8'h80, 8'h81, 8'h80, 3'h7}, '{8'h20, 8'h21, 8'h20, 3'h5}};

    vectored_interrupt_arbiter i_dut (.*);
    mem_model i_mem (.*);

    always #2 clk = ~clk;
    always @(posedge clk) if (pc_load.load === 1'b1) last_pc <= pc_load.value;

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic set_src(input logic [7:0] m);
        {end_of_message_source, uart_irq, timer_irq, external_line_four,
         external_line_three, external_line_two, nmi_in} = m[7:1];
    endtask
    task automatic wr_en(input logic [7:0] v);
        enable_wr = 1;
        enable_wdata = v;
        cyc(1);
        enable_wr = 0;
    endtask
    task automatic wr_pend(input logic [7:0] v);
        pending_wr = 1;
        pending_wdata = v;
        cyc(1);
        pending_wr = 0;
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        cyc(1);
        while (entry_busy !== 1'b0 && n < 50) begin
            cyc(1);
            n++;
        end
        if (n == 50) chk("idle", 1, 0);
    endtask
    task automatic step(input logic b, input logic r);
        instr_boundary = b;
        return_from_service_instr = r;
        cyc(1);
        {instr_boundary, return_from_service_instr} = 2'h0;
        wait_idle();
    endtask
    task automatic do_reset;
        arst_n = 0;
        cyc(12);
        chk("pend_rst", interrupt_pending_reg, 16'h0001);
        chk("en_rst", {interrupt_enable_reg, 5'h0, interrupt_condition_reg}, 16'h0000);
        chk("sp_rst", stack_pointer, 16'h0000);
        chk("flt_rst", {port_a_float, port_d_float, port_r_float}, 16'h0007);
        chk("fltb_rst", port_b_float, 16'hefff);
        arst_n = 1;
        wait_idle();
        chk("rst_vec", last_pc, 16'h0001);
        chk("flt_run", port_b_float | {port_a_float, port_d_float, port_r_float}, 0);
        chk("rst_clr", interrupt_pending_reg, 16'h0000);
    endtask
    task automatic test_done;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        #40000;
        num_errors++;
        test_done();
    end

    initial begin
        set_src(8'h00);
        {enable_wr, pending_wr, cond_wr, sp_wr, hdlc_dma_error, dma_byte_busy} = 6'h00;
        {instr_boundary, return_from_service_instr} = 2'h0;
        {enable_wdata, pending_wdata, cond_wdata, sp_wdata, pc_in} = '0;
        ack_dly = 2'h0;
        do_reset();
        sp_wr = 1;
        sp_wdata = 16'h0010;
        cyc(1);
        sp_wr = 0;
        foreach (rows[i]) begin
            ack_dly = 2'(i % 3);
            wr_en(rows[i].en);
            set_src(rows[i].src);
            cyc(3);
            set_src(8'h00);
            pc_in = 16'h2000 + 16'(i);
            step(1, 0);
            chk("rank", grant_rank, rows[i].rank);
            chk("vec", last_pc, ~(16'hfffe - 16'(2 * rows[i].rank)));
            chk("pend", interrupt_pending_reg, rows[i].pend);
            chk("glb_off", interrupt_enable_reg, rows[i].en & 8'hfe);
            chk("push_sp", stack_pointer, 16'h0012);
            step(0, 1);
            chk("ret_pc", last_pc, pc_in);
            chk("ret_en", interrupt_enable_reg, rows[i].en);
            chk("ret_sp", stack_pointer, 16'h0010);
            wr_pend(8'h00);
        end
        // Enabled source with global enable off pends but is not taken
        wr_en(8'h20);
        set_src(8'h20);
        cyc(3);
        set_src(8'h00);
        step(1, 0);
        chk("no_take", stack_pointer, 16'h0010);
        chk("no_pc", last_pc, 16'h2005);
        chk("pend_dis", interrupt_pending_reg, 16'h0020);
        wr_pend(8'h00);
        // Falling-edge polarity on the three external lines
        cond_wr = 1;
        cond_wdata = 3'h7;
        cyc(1);
        cond_wr = 0;
        chk("cond", interrupt_condition_reg, 16'h0007);
        set_src(8'h1c);
        cyc(3);
        chk("rise_ign", interrupt_pending_reg, 16'h0000);
        set_src(8'h00);
        cyc(3);
        chk("fall_hit", interrupt_pending_reg, 16'h001c);
        wr_pend(8'h00);
        set_src(8'h02);
        cyc(3);
        wr_pend(8'h00);
        set_src(8'h00);
        cyc(3);
        chk("nmi_fall", interrupt_pending_reg, 16'h0000);
        hdlc_dma_error = 1;
        cyc(3);
        hdlc_dma_error = 0;
        chk("shared", interrupt_pending_reg, 16'h0010);
        wr_pend(8'h00);
        // NMI while a DMA byte is still moving
        dma_byte_busy = 1;
        set_src(8'h02);
        cyc(3);
        set_src(8'h00);
        chk("wait_bnd", entry_busy, 0);
        instr_boundary = 1;
        cyc(1);
        instr_boundary = 0;
        cyc(4);
        chk("halt", dma_halt, 1);
        chk("hold", mem.req, 0);
        dma_byte_busy = 0;
        wait_idle();
        chk("nmi_vec", last_pc, 16'h0003);
        step(0, 1);
        chk("halt_off", dma_halt, 0);
        // Nested entry: the service routine reopens the global enable
        wr_en(8'h61);
        set_src(8'h40);
        cyc(3);
        set_src(8'h00);
        pc_in = 16'h3000;
        step(1, 0);
        wr_pend(8'h00);
        wr_en(8'h61);
        set_src(8'h20);
        cyc(3);
        set_src(8'h00);
        pc_in = 16'h3100;
        step(1, 0);
        chk("nest_rank", grant_rank, 16'h0005);
        chk("nest_sp", stack_pointer, 16'h0014);
        wr_pend(8'h00);
        step(0, 1);
        chk("nest_ret", last_pc, 16'h3100);
        step(0, 1);
        chk("outer_ret", last_pc, 16'h3000);
        chk("outer_sp", stack_pointer, 16'h0010);
        do_reset();
        test_done();
    end
endmodule // vectored_interrupt_arbiter_tb
